// *** src/epm_regs.vh ***
// constants for the alternate-pointer / multiply-accumulate execution unit
// assumes the core hands over the prefix byte and the second opcode byte together
`ifndef EPM_REGS_VH
`define EPM_REGS_VH

// prefix byte that opens the extended instruction set
`define EPM_PREFIX        8'ha5

// second opcode bytes
`define EPM_OP_BUMP       8'ha3
`define EPM_OP_BRANCH     8'h73
`define EPM_OP_LSHIFT     8'h23
`define EPM_OP_MAC        8'ha4
`define EPM_OP_XREAD      8'he0
`define EPM_OP_XWRITE     8'hf0
`define EPM_OP_CODE       8'h93
`define EPM_OP_LOADIMM    8'h90

// instruction lengths in core clock cycles
`define EPM_CYC_BUMP      4'h3
`define EPM_CYC_BRANCH    4'h3
`define EPM_CYC_LSHIFT    4'h2
`define EPM_CYC_MAC       4'h9
`define EPM_CYC_CODE      4'h3
`define EPM_CYC_LOADIMM   4'h4
`define EPM_CYC_X_ERAM    4'h3
`define EPM_CYC_X_SLOW    4'h5

// counter marks and constant operands
`define EPM_CNT_LAST      4'h1
`define EPM_CNT_ZERO      4'h0
`define EPM_STEP_ONE      8'h01
`define EPM_STEP_PC       8'h02

// fsm states, one-hot
`define EPM_ST_IDLE       3'h1
`define EPM_ST_EXEC       3'h2
`define EPM_ST_SPARE      3'h4

// reset values
`define EPM_PTR_RST       16'h0000
`define EPM_MAC_RST       40'h00_0000_0000
`define EPM_BYTE_RST      8'h00

// bit positions
`define EPM_MAC_MSB       39
`define EPM_PROD_MSB      31

`endif

// *** src/epm_add16.v ***
// 16-bit base plus unsigned 8-bit addend with an explicit low-byte carry
// assumes purely combinational use inside the execution unit
`timescale 1ns/1ps

module epm_add16 (
    // operands
    input  wire [15:0] base,
    input  wire [7:0]  addend,
    // result, wraps modulo 2^16
    output wire [15:0] sum
);

    wire [8:0] low_sum;   // low byte with carry out
    wire [7:0] high_sum;  // high byte after carry

    // low byte first, carry ripples into the high byte
    assign low_sum  = {1'b0, base[7:0]} + {1'b0, addend};
    assign high_sum = base[15:8] + {7'h00, low_sum[8]};
    assign sum      = {high_sum, low_sum[7:0]};

endmodule

// *** src/epm_exec.v ***
// execution unit for the prefixed alternate-pointer and mac instructions
// assumes all inputs come from core logic on mclk, so no synchronisers;
// memories return read data by the edge on which done is raised
`timescale 1ns/1ps
`include "epm_regs.vh"

module epm_exec (
    // clock and reset
    input  wire        mclk,
    input  wire        rstn,
    // instruction hand-over from the fetch stage
    input  wire        op_valid,
    input  wire [7:0]  op_prefix,
    input  wire [7:0]  op_byte,
    input  wire [7:0]  imm_hi,
    input  wire [7:0]  imm_lo,
    // core state read by the instructions
    input  wire [7:0]  acc_in,
    input  wire [7:0]  b_in,
    input  wire [7:0]  first_operand_upper,
    input  wire [7:0]  second_operand_upper,
    input  wire [15:0] pc_in,
    input  wire        pointer_choice,
    input  wire        ov_in,
    input  wire        target_is_extra_ram,
    // pointer writes from ordinary instructions
    input  wire        ptr_wr_en,
    input  wire        ptr_wr_sel,
    input  wire [15:0] ptr_wr_data,
    // memory read data
    input  wire [7:0]  code_rdata,
    input  wire [7:0]  data_rdata,
    // status
    output reg         busy_q,
    output reg         done_q,
    output reg         bad_op_q,
    // accumulator and flag results
    output reg         acc_wr_q,
    output reg  [7:0]  acc_out_q,
    output reg         flag_wr_q,
    output reg         ov_out_q,
    output reg         cy_out_q,
    // program counter load
    output reg         pc_load_q,
    output reg  [15:0] pc_out_q,
    // code memory request
    output reg         code_rd_q,
    output reg  [15:0] code_addr_q,
    // data memory request
    output reg         data_rd_q,
    output reg         data_wr_q,
    output reg  [15:0] data_addr_q,
    output reg  [7:0]  data_wdata_q,
    // architectural registers held here
    output reg  [15:0] first_pointer_q,
    output reg  [15:0] second_pointer_q,
    output reg  [39:0] mac_q
);

    // latched instruction context
    reg  [2:0]  state_q;     // one-hot fsm state
    reg  [2:0]  state_d;
    reg  [3:0]  cnt_q;       // cycles left in the instruction
    reg  [7:0]  op_q;        // second opcode byte
    reg         sel_q;       // pointer choice at accept time
    reg  [7:0]  acc_q;       // original accumulator
    reg  [7:0]  b_q;         // low byte of second operand
    reg  [7:0]  ax_q;        // high byte of first operand
    reg  [7:0]  bx_q;        // high byte of second operand
    reg  [15:0] pc_q;        // pc of the instruction
    reg  [15:0] imm_q;       // immediate for the pointer load
    reg         req_pend_q;  // memory strobe due next cycle

    // decode of the incoming pair
    reg  [3:0]  len_d;       // instruction length in cycles
    reg         known_d;     // opcode is one of ours
    wire        prefixed;    // prefix byte matches

    // datapath
    wire [15:0] alt_ptr;     // unselected pointer
    wire [15:0] bump_sum;    // alt pointer plus one
    wire [15:0] pc_plus2;    // pc advanced past the instruction
    wire [15:0] branch_sum;  // branch target
    wire [15:0] code_sum;    // code fetch address
    wire signed [15:0] opa;  // first signed operand
    wire signed [15:0] opb;  // second signed operand
    wire signed [31:0] prod; // signed product
    wire [39:0] prod_ext;    // product sign extended to 40 bits
    wire [39:0] mac_sum;     // accumulated sum
    wire        mac_ovf;     // two's complement overflow of the sum
    wire        commit;      // last cycle of the instruction

    // decode only after the prefix byte
    assign prefixed = (op_prefix == `EPM_PREFIX);

    // pointer not named by the choice bit: choice 0 means second
    assign alt_ptr = sel_q ? first_pointer_q : second_pointer_q;

    // signed operands, upper bytes from the extension registers
    assign opa      = $signed({ax_q, acc_q});
    assign opb      = $signed({bx_q, b_q});
    assign prod     = opa * opb;
    assign prod_ext = {{8{prod[`EPM_PROD_MSB]}}, prod};
    assign mac_sum  = mac_q + prod_ext;

    // overflow when both addends share a sign the sum does not
    assign mac_ovf = (mac_q[`EPM_MAC_MSB] == prod_ext[`EPM_MAC_MSB]) &&
                     (mac_sum[`EPM_MAC_MSB] != mac_q[`EPM_MAC_MSB]);

    assign commit = (state_q == `EPM_ST_EXEC) && (cnt_q == `EPM_CNT_LAST);

    // alt pointer plus one, 16-bit wrap
    epm_add16 u_bump (
        .base   (alt_ptr),
        .addend (`EPM_STEP_ONE),
        .sum    (bump_sum)
    );

    // pc advanced by two before the accumulator is added
    epm_add16 u_pc2 (
        .base   (pc_q),
        .addend (`EPM_STEP_PC),
        .sum    (pc_plus2)
    );

    // unsigned acc onto the advanced pc
    epm_add16 u_branch (
        .base   (pc_plus2),
        .addend (acc_q),
        .sum    (branch_sum)
    );

    // unsigned acc onto the unselected pointer
    epm_add16 u_code (
        .base   (alt_ptr),
        .addend (acc_q),
        .sum    (code_sum)
    );

    // opcode to length; external access length depends on target space
    always @* begin
        len_d   = `EPM_CYC_LSHIFT;
        known_d = 1'b1;
        case (op_byte)
            `EPM_OP_BUMP:    len_d = `EPM_CYC_BUMP;
            `EPM_OP_BRANCH:  len_d = `EPM_CYC_BRANCH;
            `EPM_OP_LSHIFT:  len_d = `EPM_CYC_LSHIFT;
            `EPM_OP_MAC:     len_d = `EPM_CYC_MAC;
            `EPM_OP_CODE:    len_d = `EPM_CYC_CODE;
            `EPM_OP_LOADIMM: len_d = `EPM_CYC_LOADIMM;
            `EPM_OP_XREAD,
            `EPM_OP_XWRITE: begin
                // on-chip extra ram is the fast space
                len_d = target_is_extra_ram ? `EPM_CYC_X_ERAM : `EPM_CYC_X_SLOW;
            end
            default: begin
                known_d = 1'b0;  // not ours, reported and dropped
            end
        endcase
    end

    // next state
    always @* begin
        state_d = state_q;
        case (state_q)
            `EPM_ST_IDLE: begin
                if (op_valid && prefixed && known_d) begin
                    state_d = `EPM_ST_EXEC;
                end
            end
            `EPM_ST_EXEC: begin
                if (cnt_q == `EPM_CNT_LAST) begin
                    state_d = `EPM_ST_IDLE;
                end
            end
            default: begin
                state_d = `EPM_ST_IDLE;  // recover from an illegal code
            end
        endcase
    end

    // state, counter and latched operands
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= `EPM_ST_IDLE;
            cnt_q      <= `EPM_CNT_ZERO;
            op_q       <= `EPM_BYTE_RST;
            sel_q      <= 1'b0;
            acc_q      <= `EPM_BYTE_RST;
            b_q        <= `EPM_BYTE_RST;
            ax_q       <= `EPM_BYTE_RST;
            bx_q       <= `EPM_BYTE_RST;
            pc_q       <= `EPM_PTR_RST;
            imm_q      <= `EPM_PTR_RST;
            req_pend_q <= 1'b0;
            busy_q     <= 1'b0;
            bad_op_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            bad_op_q <= 1'b0;
            if (state_q == `EPM_ST_IDLE) begin
                if (op_valid && prefixed && known_d) begin
                    // operands captured once; the core may change them afterwards
                    op_q       <= op_byte;
                    sel_q      <= pointer_choice;
                    acc_q      <= acc_in;
                    b_q        <= b_in;
                    ax_q       <= first_operand_upper;
                    bx_q       <= second_operand_upper;
                    pc_q       <= pc_in;
                    imm_q      <= {imm_hi, imm_lo};  // third byte high
                    cnt_q      <= len_d - `EPM_CNT_LAST;
                    req_pend_q <= 1'b1;
                    busy_q     <= 1'b1;
                end else if (op_valid) begin
                    bad_op_q <= 1'b1;  // unknown pair, no state touched
                end
            end else if (state_q == `EPM_ST_EXEC) begin
                req_pend_q <= 1'b0;
                if (cnt_q == `EPM_CNT_LAST) begin
                    busy_q <= 1'b0;
                    cnt_q  <= `EPM_CNT_ZERO;
                end else begin
                    cnt_q <= cnt_q - `EPM_CNT_LAST;
                end
            end
        end
    end

    // memory strobes, one cycle wide, on the second execute cycle
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            code_rd_q    <= 1'b0;
            code_addr_q  <= `EPM_PTR_RST;
            data_rd_q    <= 1'b0;
            data_wr_q    <= 1'b0;
            data_addr_q  <= `EPM_PTR_RST;
            data_wdata_q <= `EPM_BYTE_RST;
        end else begin
            code_rd_q <= 1'b0;
            data_rd_q <= 1'b0;
            data_wr_q <= 1'b0;
            if (req_pend_q && (state_q == `EPM_ST_EXEC)) begin
                case (op_q)
                    `EPM_OP_CODE: begin
                        code_rd_q   <= 1'b1;
                        code_addr_q <= code_sum;
                    end
                    `EPM_OP_XREAD: begin
                        data_rd_q   <= 1'b1;
                        data_addr_q <= alt_ptr;
                    end
                    `EPM_OP_XWRITE: begin
                        // acc goes out unchanged, selected pointer untouched
                        data_wr_q    <= 1'b1;
                        data_addr_q  <= alt_ptr;
                        data_wdata_q <= acc_q;
                    end
                    default: begin
                        data_addr_q <= data_addr_q;  // no access for this op
                    end
                endcase
            end
        end
    end

    // results applied on the last cycle only
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_q    <= 1'b0;
            acc_wr_q  <= 1'b0;
            acc_out_q <= `EPM_BYTE_RST;
            flag_wr_q <= 1'b0;
            ov_out_q  <= 1'b0;
            cy_out_q  <= 1'b0;
            pc_load_q <= 1'b0;
            pc_out_q  <= `EPM_PTR_RST;
        end else begin
            done_q    <= commit;
            acc_wr_q  <= 1'b0;
            flag_wr_q <= 1'b0;
            pc_load_q <= 1'b0;
            if (commit) begin
                case (op_q)
                    `EPM_OP_BRANCH: begin
                        // acc and flags are left alone
                        pc_load_q <= 1'b1;
                        pc_out_q  <= branch_sum;
                    end
                    `EPM_OP_CODE: begin
                        acc_wr_q  <= 1'b1;
                        acc_out_q <= code_rdata;
                    end
                    `EPM_OP_XREAD: begin
                        acc_wr_q  <= 1'b1;
                        acc_out_q <= data_rdata;
                    end
                    `EPM_OP_MAC: begin
                        // overflow only ever set here, never cleared
                        flag_wr_q <= 1'b1;
                        ov_out_q  <= ov_in | mac_ovf;
                        cy_out_q  <= mac_sum[`EPM_MAC_MSB];
                    end
                    default: begin
                        acc_out_q <= acc_out_q;  // no acc or flag result
                    end
                endcase
            end
        end
    end

    // pointers: instruction result wins over an ordinary write
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            first_pointer_q  <= `EPM_PTR_RST;
            second_pointer_q <= `EPM_PTR_RST;
        end else begin
            if (commit && ((op_q == `EPM_OP_BUMP) || (op_q == `EPM_OP_LOADIMM))) begin
                // choice 0 writes the second pointer
                if (sel_q) begin
                    first_pointer_q <= (op_q == `EPM_OP_BUMP) ? bump_sum : imm_q;
                end else begin
                    second_pointer_q <= (op_q == `EPM_OP_BUMP) ? bump_sum : imm_q;
                end
            end else if (ptr_wr_en) begin
                if (ptr_wr_sel) begin
                    second_pointer_q <= ptr_wr_data;
                end else begin
                    first_pointer_q <= ptr_wr_data;
                end
            end
        end
    end

    // product accumulator; operands are only read, never written
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mac_q <= `EPM_MAC_RST;
        end else if (commit) begin
            if (op_q == `EPM_OP_LSHIFT) begin
                mac_q <= {mac_q[`EPM_MAC_MSB-1:0], 1'b0};
            end else if (op_q == `EPM_OP_MAC) begin
                mac_q <= mac_sum;
            end
        end
    end

endmodule

// *** testbench/epm_exec_assertions.sv ***
// checker for the alternate-pointer and mac execution unit
// assumes it is bound to epm_exec and sees only that module's ports
`timescale 1ns/1ps
`include "epm_regs.vh"

module epm_exec_chk (
    // clock and reset
    input wire        mclk,
    input wire        rstn,
    // request side
    input wire        op_valid,
    input wire [7:0]  op_prefix,
    input wire [7:0]  op_byte,
    input wire [7:0]  acc_in,
    input wire [15:0] pc_in,
    input wire        pointer_choice,
    input wire        ov_in,
    input wire        target_is_extra_ram,
    // results
    input wire        busy_q,
    input wire        done_q,
    input wire        flag_wr_q,
    input wire        ov_out_q,
    input wire        cy_out_q,
    input wire        pc_load_q,
    input wire [15:0] pc_out_q,
    input wire        code_rd_q,
    input wire [15:0] code_addr_q,
    input wire        data_rd_q,
    input wire        data_wr_q,
    input wire [15:0] data_addr_q,
    input wire [7:0]  data_wdata_q,
    input wire [15:0] first_pointer_q,
    input wire [15:0] second_pointer_q,
    input wire [39:0] mac_q
);
    // an instruction is taken on this edge
    wire        take = op_valid && !busy_q && (op_prefix == `EPM_PREFIX);
    // the pointer that is not selected
    wire [15:0] alt = pointer_choice ? first_pointer_q : second_pointer_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    bump_len_a: assert property (take && op_byte == `EPM_OP_BUMP |-> ##3 done_q)
        else $error("bump length wrong");
    // the unselected pointer is judged by the choice at take time, the bench may move it after
    bump_step_a: assert property (take && op_byte == `EPM_OP_BUMP |-> ##3
        ($past(pointer_choice, 3) ? first_pointer_q : second_pointer_q) == $past(alt, 3) + 16'h0001)
        else $error("bump result wrong");
    branch_target_a: assert property (take && op_byte == `EPM_OP_BRANCH |-> ##3 pc_load_q
        && pc_out_q == $past(pc_in, 3) + 16'h0002 + {8'h00, $past(acc_in, 3)}) else $error("branch target wrong");
    lshift_val_a: assert property (take && op_byte == `EPM_OP_LSHIFT |-> ##2 done_q && mac_q == ($past(mac_q) << 1))
        else $error("left shift wrong");
    code_addr_a: assert property (take && op_byte == `EPM_OP_CODE |-> ##2 code_rd_q
        && code_addr_q == $past(alt, 2) + {8'h00, $past(acc_in, 2)}) else $error("code address wrong");
    mac_carry_a: assert property (take && op_byte == `EPM_OP_MAC |-> ##9 flag_wr_q && cy_out_q == mac_q[39])
        else $error("mac carry wrong");
    ov_sticky_a: assert property (flag_wr_q && $past(ov_in) |-> ov_out_q)
        else $error("overflow cleared");
    xread_fast_a: assert property (take && op_byte == `EPM_OP_XREAD && target_is_extra_ram |-> ##3 done_q)
        else $error("fast read length wrong");
    xread_slow_a: assert property (take && op_byte == `EPM_OP_XREAD && !target_is_extra_ram |-> ##5 done_q)
        else $error("slow read length wrong");
    xread_addr_a: assert property (take && op_byte == `EPM_OP_XREAD |-> ##2 data_rd_q && data_addr_q == $past(alt, 2))
        else $error("read address wrong");
    xwrite_data_a: assert property (take && op_byte == `EPM_OP_XWRITE |-> ##2 data_wr_q
        && data_addr_q == $past(alt, 2) && data_wdata_q == $past(acc_in, 2)) else $error("write wrong");

    // main scenarios reached
    cover property (take && op_byte == `EPM_OP_MAC);
    cover property (pc_load_q);
    cover property (take && op_byte == `EPM_OP_XREAD && !target_is_extra_ram);
endmodule

bind epm_exec epm_exec_chk u_epm_exec_chk (.mclk, .rstn, .op_valid, .op_prefix, .op_byte,
    .acc_in, .pc_in, .pointer_choice, .ov_in, .target_is_extra_ram, .busy_q, .done_q, .flag_wr_q,
    .ov_out_q, .cy_out_q, .pc_load_q, .pc_out_q, .code_rd_q, .code_addr_q, .data_rd_q, .data_wr_q,
    .data_addr_q, .data_wdata_q, .first_pointer_q, .second_pointer_q, .mac_q);

// *** testbench/epm_exec_tb_top.sv ***
// self-checking bench for the alternate-pointer and mac execution unit
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps
`include "epm_regs.vh"

module epm_exec_tb_top;
    // stimulus, all driven 1 ns after the rising edge
    reg         mclk = 1'b0, rstn = 1'b0, op_valid = 1'b0, pointer_choice = 1'b0;
    reg         ov_in = 1'b0, target_is_extra_ram = 1'b0, ptr_wr_en = 1'b0, ptr_wr_sel = 1'b0;
    reg  [7:0]  op_prefix = 8'h00, op_byte = 8'h00, imm_hi = 8'h00, imm_lo = 8'h00;
    reg  [7:0]  acc_in = 8'h00, b_in = 8'h00, first_operand_upper = 8'h00;
    reg  [7:0]  second_operand_upper = 8'h00, code_rdata = 8'h00, data_rdata = 8'h00;
    reg  [15:0] pc_in = 16'h0000, ptr_wr_data = 16'h0000;
    // design outputs
    wire        busy_q, done_q, bad_op_q, acc_wr_q, flag_wr_q, ov_out_q, cy_out_q;
    wire        pc_load_q, code_rd_q, data_rd_q, data_wr_q;
    wire [7:0]  acc_out_q, data_wdata_q;
    wire [15:0] pc_out_q, code_addr_q, data_addr_q, first_pointer_q, second_pointer_q;
    wire [39:0] mac_q;
    // score
    integer     error_cnt = 0, n_compared = 0;

    epm_exec u_epm_exec (.mclk, .rstn, .op_valid, .op_prefix, .op_byte, .imm_hi, .imm_lo,
        .acc_in, .b_in, .first_operand_upper, .second_operand_upper, .pc_in, .pointer_choice,
        .ov_in, .target_is_extra_ram, .ptr_wr_en, .ptr_wr_sel, .ptr_wr_data, .code_rdata,
        .data_rdata, .busy_q, .done_q, .bad_op_q, .acc_wr_q, .acc_out_q, .flag_wr_q, .ov_out_q,
        .cy_out_q, .pc_load_q, .pc_out_q, .code_rd_q, .code_addr_q, .data_rd_q, .data_wr_q,
        .data_addr_q, .data_wdata_q, .first_pointer_q, .second_pointer_q, .mac_q);

    // 10 MHz core clock
    always #50 mclk = ~mclk;

    // verdict, the single exit point
    task results;
        begin
            if (error_cnt == 0 && n_compared > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask

    // case-equal compare, so unknowns never pass
    task chk(input [39:0] got, input [39:0] exp, input [8*12:1] what);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t %0s got %h exp %h", $time, what, got, exp);
            end
        end
    endtask

    // ordinary pointer write, one cycle pulse
    task wrptr(input sel, input [15:0] val);
        begin
            @(posedge mclk); #1;
            ptr_wr_en = 1'b1;
            ptr_wr_sel = sel;
            ptr_wr_data = val;
            @(posedge mclk); #1;
            ptr_wr_en = 1'b0;
        end
    endtask

    // hand one prefixed op over and count cycles from the take cycle to done; bounded wait
    task issue(input [7:0] op, output integer n);
        begin
            @(posedge mclk); #1;
            op_valid = 1'b1;
            op_prefix = `EPM_PREFIX;
            op_byte = op;
            @(posedge mclk); #1;
            op_valid = 1'b0;
            n = 1;
            while (done_q !== 1'b1 && n < 20) begin
                @(posedge mclk); #1;
                n = n + 1;
            end
            if (done_q !== 1'b1) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t no done", $time);
                results;
            end
        end
    endtask

    // bad prefix, then unknown opcode: refused, nothing started or written
    task s_bad;
        begin
            @(posedge mclk); #1;
            op_valid = 1'b1;
            op_prefix = 8'h00;
            op_byte = `EPM_OP_BUMP;
            @(posedge mclk); #1;
            chk({bad_op_q, busy_q}, 2'b10, "bad prefix");
            op_prefix = `EPM_PREFIX;
            op_byte = 8'h11;
            @(posedge mclk); #1;
            op_valid = 1'b0;
            chk({bad_op_q, busy_q}, 2'b10, "bad opcode");
            chk({first_pointer_q, second_pointer_q}, 32'h0000_0000, "bad keep");
        end
    endtask

    // bump with low-byte carry, then wrap on the other pointer
    task s_bump;
        integer n;
        begin
            wrptr(1'b0, 16'h4321);
            wrptr(1'b1, 16'h12fe);
            repeat (3) issue(`EPM_OP_BUMP, n);
            chk(n, 3, "bump cycles");
            chk(second_pointer_q, 16'h1301, "bump carry");
            chk(first_pointer_q, 16'h4321, "bump other");
            pointer_choice = 1'b1;
            wrptr(1'b0, 16'hffff);
            issue(`EPM_OP_BUMP, n);
            chk(first_pointer_q, 16'h0000, "bump wrap");
            chk(second_pointer_q, 16'h1301, "bump keep");
            pointer_choice = 1'b0;
        end
    endtask

    // immediate load, branch across the 64k edge, code fetch with carry
    task s_ptr_ops;
        integer n;
        begin
            imm_hi = 8'h56;
            imm_lo = 8'h78;
            issue(`EPM_OP_LOADIMM, n);
            chk(second_pointer_q, 16'h5678, "load imm");
            pc_in = 16'hfff0;
            acc_in = 8'h20;
            issue(`EPM_OP_BRANCH, n);
            chk(pc_out_q, 16'h0012, "branch");
            acc_in = 8'hf0;
            code_rdata = 8'h66;
            issue(`EPM_OP_CODE, n);
            chk(code_addr_q, 16'h5768, "code addr");
            chk(acc_out_q, 8'h66, "code data");
            chk(second_pointer_q, 16'h5678, "code keep");
        end
    endtask

    // signed mac, sticky overflow, shift, then a real overflow
    task s_mac;
        integer n;
        begin
            first_operand_upper = 8'hff;
            acc_in = 8'h38;
            b_in = 8'h64;
            issue(`EPM_OP_MAC, n);
            chk(n, 9, "mac cycles");
            chk(mac_q, 40'hff_ffff_b1e0, "mac neg");
            chk({ov_out_q, cy_out_q}, 2'b01, "mac flags");
            {first_operand_upper, acc_in, second_operand_upper, b_in} = 32'h0100_0100;
            ov_in = 1'b1;
            issue(`EPM_OP_MAC, n);
            chk(mac_q, 40'h00_0000_b1e0, "mac pos");
            chk({ov_out_q, cy_out_q}, 2'b10, "mac sticky");
            ov_in = 1'b0;
            issue(`EPM_OP_LSHIFT, n);
            chk(mac_q, 40'h00_0001_63c0, "lshift");
            {first_operand_upper, acc_in, second_operand_upper, b_in} = 32'h8000_8000;
            repeat (511) issue(`EPM_OP_MAC, n);
            chk(ov_out_q, 1'b0, "no ovf yet");
            issue(`EPM_OP_MAC, n);
            chk(mac_q, 40'h80_0001_63c0, "mac wrap");
            chk({ov_out_q, cy_out_q}, 2'b11, "ovf flags");
        end
    endtask

    // external read fast and slow, then write, via the first pointer
    task s_xfer;
        integer n;
        begin
            pointer_choice = 1'b1;
            wrptr(1'b0, 16'h0abc);
            target_is_extra_ram = 1'b1;
            data_rdata = 8'h5a;
            issue(`EPM_OP_XREAD, n);
            chk(n, 3, "fast read");
            chk({data_addr_q, acc_out_q}, 24'h0abc5a, "read fast");
            chk(acc_wr_q, 1'b1, "acc strobe");
            target_is_extra_ram = 1'b0;
            data_rdata = 8'ha5;
            issue(`EPM_OP_XREAD, n);
            chk(n, 5, "slow read");
            chk(acc_out_q, 8'ha5, "read slow");
            acc_in = 8'h3c;
            issue(`EPM_OP_XWRITE, n);
            chk({data_addr_q, data_wdata_q}, 24'h0abc3c, "write");
            chk(acc_wr_q, 1'b0, "write no acc");
            pointer_choice = 1'b0;
        end
    endtask

    // reset for 8 cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        rstn = 1'b1;
        s_bad;
        s_bump;
        s_ptr_ops;
        s_mac;
        s_xfer;
        results;
    end
endmodule
